// File: verilog/ntb_passthru_config_gen.sv
// Register file and sequencer that launch configuration requests across the bridge.
//
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module ntb_passthru_config_gen #(
    parameter logic [31:0] BASE_ADDR = 32'h0000_0000
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic pwrRst,
    input wire logic clkEn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    output logic reqValid,
    input wire logic reqReady,
    output ntb_passthru_pkg::cfg_request_type req,
    input wire logic cplValid,
    input wire ntb_passthru_pkg::cfg_completion_type cpl,
    output logic reqAbort,
    output logic window4Enable
);

    typedef enum logic [1:0] {
        S_IDLE = 2'b01,
        S_BUSY = 2'b10
    } gen_state_type;

    typedef struct packed {
        gen_state_type state;
        logic windowEnable;
        ntb_passthru_pkg::cfg_target_type target;
        logic configAccessKind;
        logic accessDirection;
        logic [31:0] data;
        logic done;
        logic [2:0] code;
        logic passthruAbortFlag;
        logic abortPulse;
    } gen_regs_type;

    localparam gen_regs_type REGS_INIT = '{
        state: S_IDLE,
        windowEnable: ntb_passthru_pkg::EN_RESET,
        target: '0,
        configAccessKind: 1'b0,
        accessDirection: 1'b0,
        data: ntb_passthru_pkg::DATA_RESET,
        done: 1'b0,
        code: ntb_passthru_pkg::CPL_SUCCESS,
        passthruAbortFlag: 1'b0,
        abortPulse: 1'b0
    };

    gen_regs_type r;
    gen_regs_type next_r;
    ntb_passthru_pkg::bus_access_type access;
    ntb_passthru_pkg::cfg_request_type launchReq;
    logic [31:0] readWord;
    logic [31:0] ctrlWord;
    logic [31:0] ctrlMerged;
    logic launch;
    logic abortNow;
    logic wrSetup;
    logic wrCtrl;
    logic wrData;
    logic wrState;
    logic anyRst;

    assign anyRst = rst || pwrRst;

    // Bus slave front end.
    ahb_lite_port #(
        .BASE_ADDR(BASE_ADDR)
    ) u_port (
        .sys_clk(sys_clk),
        .rst(anyRst),
        .clkEn(clkEn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hrdata(hrdata),
        .hresp(hresp),
        .readWord(readWord),
        .access(access)
    );

    // Write decode by offset; unmapped offsets are ignored.
    always_comb
    begin
        wrSetup = 1'b0;
        wrCtrl = 1'b0;
        wrData = 1'b0;
        wrState = 1'b0;
        if (access.wrValid && access.addr == ntb_passthru_pkg::SETUP_OFFSET)
        begin
            wrSetup = 1'b1;
        end
        else if (access.wrValid && access.addr == ntb_passthru_pkg::CONTROL_OFFSET)
        begin
            wrCtrl = 1'b1;
        end
        else if (access.wrValid && access.addr == ntb_passthru_pkg::DATA_OFFSET)
        begin
            wrData = 1'b1;
        end
        else if (access.wrValid && access.addr == ntb_passthru_pkg::STATE_OFFSET)
        begin
            wrState = 1'b1;
        end
    end

    // Control word as software sees it; unused bits stay zero.
    always_comb
    begin
        ctrlWord = 32'h0000_0000;
        ctrlWord[ntb_passthru_pkg::CTRL_WORD_LSB +: 6] = r.target.wordIndex;
        ctrlWord[ntb_passthru_pkg::CTRL_EXT_LSB +: 4] = r.target.extendedWordIndex;
        ctrlWord[ntb_passthru_pkg::CTRL_FN_LSB +: 3] = r.target.targetFnIndex;
        ctrlWord[ntb_passthru_pkg::CTRL_SLOT_LSB +: 5] = r.target.targetSlotIndex;
        ctrlWord[ntb_passthru_pkg::CTRL_BUS_LSB +: 8] = r.target.bus;
        ctrlWord[ntb_passthru_pkg::CTRL_KIND_BIT] = r.configAccessKind;
        ctrlWord[ntb_passthru_pkg::CTRL_DIR_BIT] = r.accessDirection;
    end

    assign ctrlMerged = ntb_passthru_pkg::mergeBytes(ctrlWord, access.wdata, access.byteEn);

    // Read multiplexer; unmapped offsets read zero.
    always_comb
    begin
        readWord = 32'h0000_0000;
        if (access.addr == ntb_passthru_pkg::SETUP_OFFSET)
        begin
            readWord[ntb_passthru_pkg::SETUP_SPACE_BIT] = ntb_passthru_pkg::SPACE_KIND_MEMORY;
            readWord[ntb_passthru_pkg::SETUP_WIDTH_LSB +: 2] = ntb_passthru_pkg::WIDTH_32BIT;
            readWord[ntb_passthru_pkg::SETUP_CACHE_BIT] = ntb_passthru_pkg::CACHEABLE_NONE;
            readWord[ntb_passthru_pkg::SETUP_SIZE_LSB +: 6] = ntb_passthru_pkg::SIZE_4KB;
            readWord[ntb_passthru_pkg::SETUP_EN_BIT] = r.windowEnable;
        end
        else if (access.addr == ntb_passthru_pkg::CONTROL_OFFSET)
        begin
            readWord = ctrlWord;
        end
        else if (access.addr == ntb_passthru_pkg::DATA_OFFSET)
        begin
            readWord = r.data;
        end
        else if (access.addr == ntb_passthru_pkg::STATE_OFFSET)
        begin
            readWord[ntb_passthru_pkg::STATE_BUSY_BIT] = (r.state == S_BUSY);
            readWord[ntb_passthru_pkg::STATE_DONE_BIT] = r.done;
            readWord[ntb_passthru_pkg::STATE_CODE_LSB +: 3] = r.code;
            readWord[ntb_passthru_pkg::STATE_ABORT_BIT] = r.passthruAbortFlag;
            readWord[ntb_passthru_pkg::STATE_CAPABLE_BIT] = ntb_passthru_pkg::CAPABLE_VALUE;
        end
    end

    // A data write while idle launches; one while busy is refused.
    assign launch = wrData && (r.state == S_IDLE);
    assign abortNow = wrState && access.byteEn[0] && access.wdata[ntb_passthru_pkg::STATE_DONE_BIT]
                      && (r.state == S_BUSY) && !cplValid;

    // Request built from the current control settings and the launching write.
    always_comb
    begin
        launchReq.configAccessKind = r.configAccessKind;
        launchReq.accessDirection = r.accessDirection;
        launchReq.target = r.target;
        launchReq.byteEn = access.byteEn;
        launchReq.data = access.wdata;
    end

    // Register updates and the request sequencer.
    always_comb
    begin
        next_r = r;
        next_r.abortPulse = 1'b0;
        if (wrSetup && access.byteEn[3])
        begin
            next_r.windowEnable = access.wdata[ntb_passthru_pkg::SETUP_EN_BIT];
        end
        if (wrCtrl)
        begin
            next_r.target.wordIndex = ctrlMerged[ntb_passthru_pkg::CTRL_WORD_LSB +: 6];
            next_r.target.extendedWordIndex = ctrlMerged[ntb_passthru_pkg::CTRL_EXT_LSB +: 4];
            next_r.target.targetFnIndex = ctrlMerged[ntb_passthru_pkg::CTRL_FN_LSB +: 3];
            next_r.target.targetSlotIndex = ctrlMerged[ntb_passthru_pkg::CTRL_SLOT_LSB +: 5];
            next_r.target.bus = ctrlMerged[ntb_passthru_pkg::CTRL_BUS_LSB +: 8];
            next_r.configAccessKind = ctrlMerged[ntb_passthru_pkg::CTRL_KIND_BIT];
            next_r.accessDirection = ctrlMerged[ntb_passthru_pkg::CTRL_DIR_BIT];
        end
        case (r.state)
            S_IDLE:
            begin
                if (launch)
                begin
                    next_r.state = S_BUSY;
                    next_r.done = 1'b0;
                    next_r.passthruAbortFlag = 1'b0;
                    if (r.accessDirection)
                    begin
                        next_r.data = ntb_passthru_pkg::mergeBytes(r.data, access.wdata, access.byteEn);
                    end
                end
                else if (wrState && access.byteEn[0] && access.wdata[ntb_passthru_pkg::STATE_DONE_BIT])
                begin
                    next_r.done = 1'b0;
                end
            end
            S_BUSY:
            begin
                if (cplValid)
                begin
                    next_r.state = S_IDLE;
                    next_r.done = 1'b1;
                    next_r.code = cpl.code;
                    next_r.passthruAbortFlag = (cpl.code == ntb_passthru_pkg::CPL_REQUESTER_ABORT);
                    if (!r.accessDirection)
                    begin
                        next_r.data = cpl.data;
                    end
                end
                else if (abortNow)
                begin
                    next_r.state = S_IDLE;
                    next_r.done = 1'b1;
                    next_r.code = ntb_passthru_pkg::CPL_REQUESTER_ABORT;
                    next_r.passthruAbortFlag = 1'b1;
                    next_r.abortPulse = 1'b1;
                end
            end
            default:
            begin
                next_r.state = S_IDLE;
            end
        endcase
        if (rst)
        begin
            next_r = r;
            next_r.state = S_IDLE;
            next_r.configAccessKind = 1'b0;
            next_r.code = ntb_passthru_pkg::CPL_SUCCESS;
            next_r.passthruAbortFlag = 1'b0;
            next_r.abortPulse = 1'b0;
        end
    end

    // Power-on reset clears everything; hot reset acts even with the clock enable low.
    always_ff @(posedge sys_clk)
    begin
        if (pwrRst)
        begin
            r <= REGS_INIT;
        end
        else if (clkEn || rst)
        begin
            r <= next_r;
        end
    end

    // Holds the request on the far-side handshake.
    cfg_request_launcher u_launcher (
        .sys_clk(sys_clk),
        .rst(anyRst),
        .clkEn(clkEn),
        .launch(launch),
        .cancel(abortNow),
        .launchReq(launchReq),
        .reqValid(reqValid),
        .reqReady(reqReady),
        .req(req)
    );

    assign reqAbort = r.abortPulse;
    assign window4Enable = r.windowEnable;

endmodule : ntb_passthru_config_gen
`default_nettype wire

// File: verilog/ntb_passthru_pkg.sv
// Shared constants, types and helpers for the bridge configuration request generator.
package ntb_passthru_pkg;

    // Register byte offsets within the 4KB register block.
    localparam logic [11:0] SETUP_OFFSET = 12'h09C;
    localparam logic [11:0] CONTROL_OFFSET = 12'h0A0;
    localparam logic [11:0] DATA_OFFSET = 12'h0A4;
    localparam logic [11:0] STATE_OFFSET = 12'h0A8;
    localparam int ADDR_BITS = 12;

    // Window setup fields; every field except the enable is fixed.
    localparam int SETUP_SPACE_BIT = 0;
    localparam int SETUP_WIDTH_LSB = 1;
    localparam int SETUP_CACHE_BIT = 3;
    localparam int SETUP_SIZE_LSB = 4;
    localparam int SETUP_EN_BIT = 31;
    localparam logic SPACE_KIND_MEMORY = 1'b0;
    localparam logic [1:0] WIDTH_32BIT = 2'h0;
    localparam logic CACHEABLE_NONE = 1'b0;
    localparam logic [5:0] SIZE_4KB = 6'h0C;
    localparam logic EN_RESET = 1'b0;

    // Control register fields.
    localparam int CTRL_WORD_LSB = 2;
    localparam int CTRL_EXT_LSB = 8;
    localparam int CTRL_FN_LSB = 12;
    localparam int CTRL_SLOT_LSB = 15;
    localparam int CTRL_BUS_LSB = 20;
    localparam int CTRL_KIND_BIT = 30;
    localparam int CTRL_DIR_BIT = 31;

    // State register fields.
    localparam int STATE_BUSY_BIT = 0;
    localparam int STATE_DONE_BIT = 1;
    localparam int STATE_CODE_LSB = 2;
    localparam int STATE_ABORT_BIT = 5;
    localparam int STATE_CAPABLE_BIT = 31;
    localparam logic CAPABLE_VALUE = 1'b1;

    // Reset value of the data register, and the size code of a word transfer.
    localparam logic [31:0] DATA_RESET = 32'h0000_0000;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // Completion codes reported in the state register.
    typedef enum logic [2:0] {
        CPL_SUCCESS = 3'h0,
        CPL_UNSUPPORTED = 3'h1,
        CPL_RETRY = 3'h2,
        CPL_COMPLETER_ABORT = 3'h3,
        CPL_REQUESTER_ABORT = 3'h4
    } cpl_code_type;

    // Target of a generated configuration request.
    typedef struct packed {
        logic [7:0] bus;
        logic [4:0] targetSlotIndex;
        logic [2:0] targetFnIndex;
        logic [3:0] extendedWordIndex;
        logic [5:0] wordIndex;
    } cfg_target_type;

    // One configuration request toward the far side of the bridge.
    typedef struct packed {
        logic accessDirection;
        logic configAccessKind;
        cfg_target_type target;
        logic [3:0] byteEn;
        logic [31:0] data;
    } cfg_request_type;

    // Completion returned from the far side.
    typedef struct packed {
        logic [2:0] code;
        logic [31:0] data;
    } cfg_completion_type;

    // Register access handed from the bus port to the register file.
    typedef struct packed {
        logic wrValid;
        logic rdValid;
        logic [11:0] addr;
        logic [3:0] byteEn;
        logic [31:0] wdata;
    } bus_access_type;

    // Byte lanes touched by a transfer of the given size and address.
    function automatic logic [3:0] byteEnables(input logic [2:0] size, input logic [1:0] addr);
        logic [3:0] lanes;
        lanes = 4'hF;
        if (size == 3'h0)
        begin
            lanes = 4'h1 << addr;
        end
        else if (size == 3'h1)
        begin
            lanes = addr[1] ? 4'hC : 4'h3;
        end
        return lanes;
    endfunction : byteEnables

    // Replaces only the enabled bytes of a word.
    function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] fresh,
                                               input logic [3:0] be);
        logic [31:0] merged;
        merged = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                merged[i*8 +: 8] = fresh[i*8 +: 8];
            end
        end
        return merged;
    endfunction : mergeBytes

endpackage : ntb_passthru_pkg

// File: verilog/ahb_lite_port.sv
// AHB-Lite slave front end that turns bus transfers into register accesses.
`timescale 1ns/1ps
`default_nettype none
module ahb_lite_port #(
    parameter logic [31:0] BASE_ADDR = 32'h0000_0000
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic [31:0] readWord,
    output ntb_passthru_pkg::bus_access_type access
);

    // The register block must sit on a 4KB boundary.
    if (BASE_ADDR[11:0] != 12'h000)
    begin : gBaseCheck
        $error("BASE_ADDR must be aligned to 4KB.");
    end

    typedef enum logic [3:0] {
        P_IDLE = 4'b0001,
        P_WRITE = 4'b0010,
        P_READ_WAIT = 4'b0100,
        P_READ_DONE = 4'b1000
    } port_state_type;

    typedef struct packed {
        port_state_type state;
        logic [11:0] addr;
        logic [3:0] byteEn;
        logic [31:0] rdata;
    } port_regs_type;

    port_regs_type r;
    port_regs_type next_r;
    logic takeAddr;

    // A new address phase is taken when an active transfer selects the block in its 4KB range and the bus is ready.
    assign takeAddr = hsel && htrans[1] && hready && (haddr[31:12] == BASE_ADDR[31:12]);

    // Reads stall one cycle so that hrdata always comes from a flip-flop.
    always_comb
    begin
        next_r = r;
        if (r.state == P_READ_WAIT)
        begin
            next_r.rdata = readWord;
            next_r.state = P_READ_DONE;
        end
        else if (takeAddr)
        begin
            next_r.addr = haddr[11:0];
            next_r.byteEn = ntb_passthru_pkg::byteEnables(hsize, haddr[1:0]);
            next_r.state = hwrite ? P_WRITE : P_READ_WAIT;
        end
        else
        begin
            next_r.state = P_IDLE;
        end
    end

    // State register; reset returns the port to idle.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            r <= '{state: P_IDLE, addr: 12'h000, byteEn: 4'h0, rdata: 32'h0000_0000};
        end
        else if (clkEn)
        begin
            r <= next_r;
        end
    end

    // Bus answers and the access strobes toward the register file.
    assign hreadyout = (r.state != P_READ_WAIT);
    assign hrdata = r.rdata;
    assign hresp = 1'b0;
    assign access.wrValid = (r.state == P_WRITE) && clkEn;
    assign access.rdValid = (r.state == P_READ_WAIT) && clkEn;
    assign access.addr = r.addr;
    assign access.byteEn = r.byteEn;
    assign access.wdata = hwdata;

endmodule : ahb_lite_port
`default_nettype wire

// File: verilog/cfg_request_launcher.sv
// Holds one generated configuration request until the far side accepts it.
`timescale 1ns/1ps
`default_nettype none
module cfg_request_launcher (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic launch,
    input wire logic cancel,
    input wire ntb_passthru_pkg::cfg_request_type launchReq,
    output logic reqValid,
    input wire logic reqReady,
    output ntb_passthru_pkg::cfg_request_type req
);

    typedef enum logic [1:0] {
        L_IDLE = 2'b01,
        L_HOLD = 2'b10
    } launch_state_type;

    typedef struct packed {
        launch_state_type state;
        ntb_passthru_pkg::cfg_request_type req;
    } launch_regs_type;

    launch_regs_type r;
    launch_regs_type next_r;

    // A cancel drops a request that has not yet been accepted.
    always_comb
    begin
        next_r = r;
        case (r.state)
            L_IDLE:
            begin
                if (launch && !cancel)
                begin
                    next_r.req = launchReq;
                    next_r.state = L_HOLD;
                end
            end
            L_HOLD:
            begin
                if (cancel || reqReady)
                begin
                    next_r.state = L_IDLE;
                end
            end
            default:
            begin
                next_r.state = L_IDLE;
            end
        endcase
    end

    // State register.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            r <= '{state: L_IDLE, req: '0};
        end
        else if (clkEn)
        begin
            r <= next_r;
        end
    end

    assign reqValid = (r.state == L_HOLD);
    assign req = r.req;

endmodule : cfg_request_launcher
`default_nettype wire

// File: verification/cfg_gen_sva.sv
// Concurrent checks on the request generator ports.
`timescale 1ns/1ps
`default_nettype none
module cfg_gen_sva (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic pwrRst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic reqValid,
    input wire logic reqReady,
    input wire ntb_passthru_pkg::cfg_request_type req,
    input wire logic cplValid,
    input wire logic reqAbort,
    input wire logic window4Enable
);
    logic wrCtl, wrDat, wrSts, pend;
    logic [31:0] ctl, dat;
    wire logic tk = hsel && htrans[1] && hready && hwrite;
    // Shadows of control and data words, and whether a request is open.
    always_ff @(posedge sys_clk)
    begin
        wrCtl <= tk && haddr[11:0] == 12'h0A0;
        wrDat <= tk && haddr[11:0] == 12'h0A4 && !pend;
        wrSts <= tk && haddr[11:0] == 12'h0A8;
        pend <= !(rst || pwrRst || cplValid || reqAbort) && (pend || reqValid);
        if (wrCtl && hready)
            ctl <= hwdata;
        if (wrDat && hready)
            dat <= hwdata;
        if (pwrRst)
            ctl <= 32'h0;
        else if (rst)
            ctl[30] <= 1'b0;
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst || pwrRst);
    sequence s_abort; wrSts && hready && hwdata[1] && reqValid && !reqReady; endsequence
    property p_launch; wrDat && hready |=> reqValid; endproperty
    a_launch: assert property (p_launch) else $error("no launch");
    property p_drop; reqValid && reqReady |=> !reqValid; endproperty
    a_drop: assert property (p_drop) else $error("extra request");
    property p_hold; reqValid && !reqReady && !(wrSts && hwdata[1]) |=> reqValid && $stable(req); endproperty
    a_hold: assert property (p_hold) else $error("request moved");
    property p_abort; s_abort |=> !reqValid ##[0:1] reqAbort; endproperty
    a_abort: assert property (p_abort) else $error("abort lost");
    property p_target; $rose(reqValid) |-> req.target == ctl[27:2]; endproperty
    a_target: assert property (p_target) else $error("bad target");
    property p_kind; $rose(reqValid) |-> {req.accessDirection, req.configAccessKind} == ctl[31:30]; endproperty
    a_kind: assert property (p_kind) else $error("bad kind");
    property p_data; $rose(reqValid) |-> req.byteEn == 4'hF && (!ctl[31] || req.data == dat); endproperty
    a_data: assert property (p_data) else $error("bad payload");
    property p_keep; disable iff (pwrRst) rst |=> window4Enable == $past(window4Enable); endproperty
    a_keep: assert property (p_keep) else $error("lost window enable");
endmodule : cfg_gen_sva
bind ntb_passthru_config_gen cfg_gen_sva u_sva (.sys_clk, .rst, .pwrRst, .hsel, .haddr, .htrans, .hwrite,
    .hready, .hwdata, .reqValid, .reqReady, .req, .cplValid, .reqAbort, .window4Enable);
`default_nettype wire

// File: verification/far_side_model.sv
// Far side model that accepts requests and returns completions.
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic stall,
    input wire logic [3:0] lag,
    input wire ntb_passthru_pkg::cfg_completion_type give,
    input wire logic reqValid,
    output logic reqReady,
    output logic cplValid,
    output ntb_passthru_pkg::cfg_completion_type cpl
);
    logic held;
    logic [3:0] cnt;
    // Outside a completion the lines show the inverse, never stale data.
    assign cpl = cplValid ? give : ~give;
    always_ff @(posedge sys_clk)
    begin
        reqReady <= 1'b0;
        cplValid <= 1'b0;
        cnt <= (reqValid || held) ? cnt + 4'h1 : 4'h0;
        if (rst)
            held <= 1'b0;
        else if (!held && reqValid && !reqReady && !stall && cnt >= lag)
        begin
            reqReady <= 1'b1;
            held <= 1'b1;
            cnt <= 4'h0;
        end
        else if (held && cnt == lag)
        begin
            cplValid <= 1'b1;
            held <= 1'b0;
        end
    end
endmodule : far_side_model
`default_nettype wire

// File: verification/tb_top.sv
// Self-checking bench for the configuration request generator.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic sys_clk = 1'b0, rst = 1'b1, pwrRst = 1'b1, hsel = 1'b1, hwrite = 1'b0, stall = 1'b0, clkEn = 1'b1;
    logic hreadyout, hresp, reqValid, reqReady, cplValid, reqAbort, window4Enable;
    logic [1:0] htrans = 2'h0;
    logic [3:0] lag = 4'h1;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, seed = 32'h5, v, c, d;
    ntb_passthru_pkg::cfg_request_type req;
    ntb_passthru_pkg::cfg_completion_type cpl, give = 35'h0;
    int num_errors = 0, n_tests = 0, cyc = 0;
    initial forever #12.5 sys_clk = ~sys_clk;
    ntb_passthru_config_gen u_dut (.sys_clk, .rst, .pwrRst, .clkEn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(ntb_passthru_pkg::HSIZE_WORD), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
        .reqValid, .reqReady, .req, .cplValid, .cpl, .reqAbort, .window4Enable);
    far_side_model u_far (.sys_clk, .rst(rst || pwrRst), .stall, .lag, .give, .reqValid, .reqReady, .cplValid, .cpl);
    // Xorshift source with a fixed start.
    function automatic logic [31:0] nxt();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : nxt
    // State word expected after a completion.
    function automatic logic [31:0] expState(input logic [2:0] code);
        return {1'b1, 25'h0, code == 3'h4, code, 2'h2};
    endfunction : expState
    // Counts one comparison and reports a mismatch.
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        n_tests++;
        if (seen !== want)
        begin
            num_errors++;
            $display("BAD %0t got %h want %h", $time, seen, want);
        end
    endtask : chk
    // One single word transfer; read data lands in v.
    task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {20'h0, a};
        @(posedge sys_clk iff hreadyout === 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge sys_clk iff hreadyout === 1'b1);
        v = hrdata;
    endtask : ahb
    // Prints the verdict and ends the run.
    task automatic stop_test();
        if (num_errors == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test
    // Cuts a hung run short.
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            num_errors++;
            stop_test();
        end
    end
    // Register checks, launches of every code, an abort and a hot reset.
    initial
    begin
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        pwrRst <= 1'b0;
        ahb(1'b0, 12'h09C, 32'h0);
        chk(v, 32'h0000_00C0);
        chk({31'h0, hresp}, 32'h0);
        ahb(1'b1, 12'h09C, 32'hFFFF_FFFF);
        ahb(1'b0, 12'h09C, 32'h0);
        chk(v, 32'h8000_00C0);
        chk({31'h0, window4Enable}, 32'h1);
        for (int i = 0; i < 10; i++)
        begin
            c = nxt();
            d = nxt();
            lag <= 4'(nxt() % 7) + 4'h1;
            give <= {3'(i % 5), nxt()};
            ahb(1'b1, 12'h0A0, c);
            ahb(1'b0, 12'h0A0, 32'h0);
            chk(v, c & 32'hCFFF_FFFC);
            ahb(1'b1, 12'h0A4, d);
            v = 32'h0;
            while (v[1] !== 1'b1)
                ahb(1'b0, 12'h0A8, 32'h0);
            chk(v, expState(give.code));
            ahb(1'b0, 12'h0A4, 32'h0);
            chk(v, c[31] ? d : give.data);
            ahb(1'b1, 12'h0A8, 32'h2);
            ahb(1'b0, 12'h0A8, 32'h0);
            chk(v & 32'h3, 32'h0);
        end
        stall <= 1'b1;
        ahb(1'b1, 12'h0A4, nxt());
        ahb(1'b0, 12'h0A8, 32'h0);
        chk(v & 32'h23, 32'h1);
        ahb(1'b1, 12'h0A8, 32'h2);
        ahb(1'b0, 12'h0A8, 32'h0);
        chk(v, 32'h8000_0032);
        stall <= 1'b0;
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        ahb(1'b0, 12'h0A0, 32'h0);
        chk(v, c & 32'h8FFF_FFFC);
        ahb(1'b0, 12'h0A8, 32'h0);
        chk(v, 32'h8000_0002);
        chk({31'h0, window4Enable}, 32'h1);
        // A write while the clock enable is low must leave the enable untouched.
        clkEn <= 1'b0;
        ahb(1'b1, 12'h09C, 32'h0);
        clkEn <= 1'b1;
        ahb(1'b0, 12'h09C, 32'h0);
        chk(v, 32'h8000_00C0);
        chk({31'h0, window4Enable}, 32'h1);
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
